// >>> logic/cou_pkg.sv
// constants shared by the operand unit: op codes, flag layout, reset values.
// assumes one clock and an asynchronous active-high reset around it.
package cou_pkg;
   // operation codes on op_code_i
   localparam logic [3:0] COU_OP_SIGN_W = 4'h0;
   localparam logic [3:0] COU_OP_SIGN_L = 4'h1;
   localparam logic [3:0] COU_OP_BOUND = 4'h2;
   localparam logic [3:0] COU_OP_SDIV = 4'h3;
   localparam logic [3:0] COU_OP_BIT_CLR = 4'h4;
   localparam logic [3:0] COU_OP_BIT_SET = 4'h5;
   localparam logic [3:0] COU_OP_BIT_INV = 4'h6;
   localparam logic [3:0] COU_OP_DEC_ADD = 4'h7;
   localparam logic [3:0] COU_OP_LINK = 4'h8;
   // flag positions in the five-bit condition code {x,n,z,v,c}
   localparam int COU_F_C = 0;
   localparam int COU_F_V = 1;
   localparam int COU_F_Z = 2;
   localparam int COU_F_N = 3;
   localparam int COU_F_X = 4;
   localparam logic [4:0] COU_CCR_RST = 5'h00;
   // word step of the bus and long push size
   localparam logic [31:0] COU_WORD_STEP = 32'h0000_0002;
   localparam logic [31:0] COU_LONG_STEP = 32'h0000_0004;
   // multi-register load states
   typedef enum logic [3:0] {
      COU_MM_IDLE = 4'b0001,
      COU_MM_HI = 4'b0010,
      COU_MM_LO = 4'b0100,
      COU_MM_XTRA = 4'b1000
   } cou_mm_t;
endpackage

// >>> logic/cou_unit.sv
// operand unit: one-shot operations on a data register and a multi-register
// load sequencer that fetches words over a simple request/acknowledge read port.
// assumes the register file and the bus live outside and follow the handshake.
`timescale 1ns/1ps
`default_nettype none
module cou_unit
   import cou_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic op_start_i,
   input wire logic [3:0] op_code_i,
   input wire logic [31:0] data_register_i,
   input wire logic [31:0] src_i,
   input wire logic [4:0] bit_num_i,
   input wire logic bit_long_i,
   input wire logic [31:0] areg_i,
   input wire logic [31:0] sp_i,
   input wire logic mm_start_i,
   input wire logic [31:0] mm_addr_i,
   input wire logic [3:0] mm_first_i,
   input wire logic [3:0] mm_count_i,
   input wire logic rd_ack_i,
   input wire logic [15:0] rd_data_i,
   output logic done_o,
   output logic [31:0] result_o,
   output logic [4:0] ccr_o,
   output logic trap_o,
   output logic [31:0] areg_o,
   output logic [31:0] sp_o,
   output logic push_o,
   output logic [31:0] push_addr_o,
   output logic [31:0] push_data_o,
   output logic rd_req_o,
   output logic [31:0] rd_addr_o,
   output logic ld_o,
   output logic [3:0] ld_idx_o,
   output logic [31:0] ld_data_o,
   output logic mm_busy_o
);
   logic [31:0] res_d;
   logic [4:0] ccr_d;
   logic trap_d;
   logic [4:0] bsel;
   logic bit_old;
   logic [31:0] bmask;
   logic signed [31:0] dividend;
   logic signed [15:0] divisor;
   logic signed [31:0] quo;
   logic signed [31:0] rem;
   logic [4:0] lo_sum;
   logic [4:0] lo_adj;
   logic [4:0] hi_sum;
   logic [4:0] hi_adj;
   logic lo_cy;
   logic hi_cy;
   logic [31:0] sp_dec;
   cou_mm_t mm_q;
   logic [15:0] hi_word_q;
   logic [3:0] left_q;

   // operation datapath; flags not named by an operation pass through
   always_comb begin
      res_d = data_register_i;
      ccr_d = ccr_o;
      trap_d = 1'b0;
      bsel = bit_long_i ? bit_num_i : {2'b00, bit_num_i[2:0]};
      bmask = 32'h0000_0001 << bsel;
      bit_old = data_register_i[bsel];
      dividend = data_register_i;
      divisor = src_i[15:0];
      quo = 32'h0000_0000;
      rem = 32'h0000_0000;
      if (divisor != 16'sh0000) begin
         quo = dividend / divisor;
         rem = dividend % divisor;
      end
      lo_sum = {1'b0, data_register_i[3:0]} + {1'b0, src_i[3:0]} + {4'h0, ccr_o[COU_F_X]};
      lo_cy = lo_sum > 5'h09;
      lo_adj = lo_cy ? lo_sum + 5'h06 : lo_sum;
      hi_sum = {1'b0, data_register_i[7:4]} + {1'b0, src_i[7:4]} + {4'h0, lo_cy};
      hi_cy = hi_sum > 5'h09;
      hi_adj = hi_cy ? hi_sum + 5'h06 : hi_sum;
      case (op_code_i)
         COU_OP_SIGN_W: begin
            res_d = {data_register_i[31:16], {8{data_register_i[7]}}, data_register_i[7:0]};
            ccr_d[COU_F_N] = data_register_i[7];
            ccr_d[COU_F_Z] = data_register_i[7:0] == 8'h00;
            ccr_d[COU_F_V] = 1'b0;
            ccr_d[COU_F_C] = 1'b0;
         end
         COU_OP_SIGN_L: begin
            res_d = {{16{data_register_i[15]}}, data_register_i[15:0]};
            ccr_d[COU_F_N] = data_register_i[15];
            ccr_d[COU_F_Z] = data_register_i[15:0] == 16'h0000;
            ccr_d[COU_F_V] = 1'b0;
            ccr_d[COU_F_C] = 1'b0;
         end
         COU_OP_BOUND: begin
            // below zero traps with n set, above bound traps with n clear
            if (data_register_i[15]) begin
               trap_d = 1'b1;
               ccr_d[COU_F_N] = 1'b1;
            end else if ($signed(data_register_i[15:0]) > $signed(src_i[15:0])) begin
               trap_d = 1'b1;
               ccr_d[COU_F_N] = 1'b0;
            end
         end
         COU_OP_SDIV: begin
            if (divisor == 16'sh0000) begin
               trap_d = 1'b1; // zero divisor traps, register untouched
            end else if (quo > 32'sh0000_7FFF || quo < -32'sh0000_8000) begin
               ccr_d[COU_F_V] = 1'b1; // overflow leaves the register as it was
               ccr_d[COU_F_C] = 1'b0;
            end else begin
               res_d = {rem[15:0], quo[15:0]};
               ccr_d[COU_F_N] = quo[15];
               ccr_d[COU_F_Z] = quo[15:0] == 16'h0000;
               ccr_d[COU_F_V] = 1'b0;
               ccr_d[COU_F_C] = 1'b0;
            end
         end
         COU_OP_BIT_CLR: begin
            ccr_d[COU_F_Z] = ~bit_old;
            res_d = data_register_i & ~bmask;
         end
         COU_OP_BIT_SET: begin
            ccr_d[COU_F_Z] = ~bit_old;
            res_d = data_register_i | bmask;
         end
         COU_OP_BIT_INV: begin
            ccr_d[COU_F_Z] = ~bit_old;
            res_d = data_register_i ^ bmask;
         end
         COU_OP_DEC_ADD: begin
            res_d = {data_register_i[31:8], hi_adj[3:0], lo_adj[3:0]};
            ccr_d[COU_F_C] = hi_cy;
            ccr_d[COU_F_X] = hi_cy;
            if ({hi_adj[3:0], lo_adj[3:0]} != 8'h00) begin
               ccr_d[COU_F_Z] = 1'b0; // z only ever cleared, for chained bytes
            end
         end
         default: begin
            res_d = data_register_i;
         end
      endcase
   end

   // stack pointer after the push of the address register
   assign sp_dec = sp_i - COU_LONG_STEP;

   // operation results and flags, one cycle after the start strobe
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         done_o <= 1'b0;
         result_o <= 32'h0000_0000;
         ccr_o <= COU_CCR_RST;
         trap_o <= 1'b0;
      end else begin
         done_o <= op_start_i;
         trap_o <= op_start_i && trap_d;
         if (op_start_i) begin
            result_o <= res_d;
            ccr_o <= ccr_d;
         end
      end
   end

   // frame link: push, copy, allocate
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         push_o <= 1'b0;
         push_addr_o <= 32'h0000_0000;
         push_data_o <= 32'h0000_0000;
         areg_o <= 32'h0000_0000;
         sp_o <= 32'h0000_0000;
      end else begin
         push_o <= op_start_i && op_code_i == COU_OP_LINK;
         if (op_start_i && op_code_i == COU_OP_LINK) begin
            push_addr_o <= sp_dec;
            push_data_o <= areg_i;
            areg_o <= sp_dec;
            sp_o <= sp_dec + {{16{src_i[15]}}, src_i[15:0]};
         end
      end
   end

   // multi-register load sequencer; only reader of data memory
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         mm_q <= COU_MM_IDLE;
         rd_req_o <= 1'b0;
         rd_addr_o <= 32'h0000_0000;
         hi_word_q <= 16'h0000;
         left_q <= 4'h0;
         ld_o <= 1'b0;
         ld_idx_o <= 4'h0;
         ld_data_o <= 32'h0000_0000;
         mm_busy_o <= 1'b0;
      end else begin
         ld_o <= 1'b0;
         case (mm_q)
            COU_MM_IDLE: begin
               if (mm_start_i && mm_count_i != 4'h0) begin
                  mm_q <= COU_MM_HI;
                  rd_req_o <= 1'b1;
                  rd_addr_o <= mm_addr_i;
                  left_q <= mm_count_i;
                  ld_idx_o <= mm_first_i - 4'h1;
                  mm_busy_o <= 1'b1;
               end
            end
            COU_MM_HI: begin
               if (rd_ack_i) begin
                  hi_word_q <= rd_data_i;
                  rd_addr_o <= rd_addr_o + COU_WORD_STEP;
                  mm_q <= COU_MM_LO;
               end
            end
            COU_MM_LO: begin
               if (rd_ack_i) begin
                  ld_o <= 1'b1;
                  ld_idx_o <= ld_idx_o + 4'h1;
                  ld_data_o <= {hi_word_q, rd_data_i};
                  left_q <= left_q - 4'h1;
                  rd_addr_o <= rd_addr_o + COU_WORD_STEP;
                  mm_q <= (left_q == 4'h1) ? COU_MM_XTRA : COU_MM_HI;
               end
            end
            COU_MM_XTRA: begin
               if (rd_ack_i) begin
                  rd_req_o <= 1'b0; // spare word past the area is dropped
                  mm_busy_o <= 1'b0;
                  mm_q <= COU_MM_IDLE;
               end
            end
            default: begin
               mm_q <= COU_MM_IDLE;
               rd_req_o <= 1'b0;
               mm_busy_o <= 1'b0;
            end
         endcase
      end
   end

   // checks on the datapath and the sequencer
   bound_pass_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (op_start_i && op_code_i == COU_OP_BOUND && !data_register_i[15]
       && $signed(data_register_i[15:0]) <= $signed(src_i[15:0])) |=> !trap_o)
      else $error("bounds check trapped on a value in range");
   bound_neg_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (op_start_i && op_code_i == COU_OP_BOUND && data_register_i[15]) |=> trap_o && ccr_o[COU_F_N])
      else $error("negative value did not trap");
   sign_word_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (op_start_i && op_code_i == COU_OP_SIGN_W) |=> result_o[15:8] == {8{$past(data_register_i[7])}})
      else $error("word extension wrong");
   div_split_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (op_start_i && op_code_i == COU_OP_SDIV && src_i[15:0] == 16'h0001)
      |=> result_o[15:0] == $past(data_register_i[15:0]) || ccr_o[COU_F_V])
      else $error("divide by one wrong");
   bit_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (op_start_i && op_code_i == COU_OP_BIT_CLR) |=> ccr_o[COU_F_Z] == !$past(bit_old)
      && result_o[$past(bsel)] == 1'b0)
      else $error("bit clear wrong");
   flag_keep_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (op_start_i && op_code_i == COU_OP_BIT_SET) |=> ccr_o[COU_F_X] == $past(ccr_o[COU_F_X])
      && ccr_o[COU_F_C] == $past(ccr_o[COU_F_C]))
      else $error("bit set touched an unrelated flag");
   link_frame_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (op_start_i && op_code_i == COU_OP_LINK) |=> push_o && areg_o == $past(sp_i) - 32'h4
      && push_data_o == $past(areg_i))
      else $error("link frame wrong");
   spare_read_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (mm_q == COU_MM_LO && rd_ack_i && left_q == 4'h1) |=> rd_req_o && mm_q == COU_MM_XTRA ##0 ld_o)
      else $error("no spare word read after the last register");
   read_only_mm_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      rd_req_o |-> mm_busy_o)
      else $error("data read outside the multi-register load");
endmodule
`default_nettype wire

// >>> tb/cou_mem_model.sv
// memory model on the word read port of the operand unit
// assumes requests hold until acknowledged; slow_i adds two idle cycles a word
`timescale 1ns/1ps
`default_nettype none
module cou_mem_model (
   input wire logic mclk_i,
   input wire logic rd_req_i,
   input wire logic [31:0] rd_addr_i,
   input wire logic slow_i,
   output logic rd_ack_o,
   output logic [15:0] rd_data_o
);
   int wait_q = 0;
   // one word per acknowledge; between words the data lines toggle, carrying the stale word again every second idle cycle
   always @(negedge mclk_i) begin
      if (!rd_req_i || wait_q != 0) begin
         rd_ack_o <= 1'h0;
         rd_data_o <= ~rd_data_o; // inverted so a sample one cycle late cannot match
         wait_q <= rd_req_i ? wait_q - 1 : 0;
      end else begin
         rd_ack_o <= 1'h1;
         rd_data_o <= rd_addr_i[15:0] ^ 16'h5A5A;
         wait_q <= slow_i ? 2 : 0;
      end
   end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the operand unit, one task per scenario
// assumes the memory model answers every read request of the unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import cou_pkg::*;
   logic mclk_i = 1'h0, rst_i = 1'h1, op_start_i = 1'h0, bit_long_i = 1'h0, mm_start_i = 1'h0, slow = 1'h0;
   logic [3:0] op_code_i = 4'h0, mm_first_i = 4'h0, mm_count_i = 4'h0, ld_idx_o;
   logic [31:0] data_register_i = 32'h0, src_i = 32'h0, areg_i = 32'h0000_1000, sp_i = 32'h0000_2000;
   logic [31:0] mm_addr_i = 32'h0, result_o, areg_o, sp_o, push_addr_o, push_data_o, rd_addr_o, ld_data_o;
   logic [4:0] bit_num_i = 5'h00, ccr_o;
   logic [15:0] rd_data_i;
   logic rd_ack_i, done_o, trap_o, push_o, rd_req_o, ld_o, mm_busy_o;
   logic [31:0] rd_q[$];
   logic [35:0] ld_q[$];
   int err_count = 0, n_checks = 0, cyc = 0;
   cou_unit i_dut (.mclk_i, .rst_i, .op_start_i, .op_code_i, .data_register_i, .src_i, .bit_num_i,
      .bit_long_i, .areg_i, .sp_i, .mm_start_i, .mm_addr_i, .mm_first_i, .mm_count_i, .rd_ack_i,
      .rd_data_i, .done_o, .result_o, .ccr_o, .trap_o, .areg_o, .sp_o, .push_o, .push_addr_o,
      .push_data_o, .rd_req_o, .rd_addr_o, .ld_o, .ld_idx_o, .ld_data_o, .mm_busy_o);
   cou_mem_model i_mem (.mclk_i, .rd_req_i(rd_req_o), .rd_addr_i(rd_addr_o), .slow_i(slow),
      .rd_ack_o(rd_ack_i), .rd_data_o(rd_data_i));
   initial forever #2 mclk_i = ~mclk_i;
   // logs every word read and register load, and cuts a hang short
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (rd_ack_i && rd_req_o) rd_q.push_back(rd_addr_o);
      if (ld_o) ld_q.push_back({ld_idx_o, ld_data_o});
      if (cyc == 20000) begin
         err_count++;
         final_report();
      end
   end
   function automatic logic [15:0] mw(input logic [31:0] a);
      return a[15:0] ^ 16'h5A5A;
   endfunction
   task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   // one operation: start pulse, then wait for done under a bound
   task automatic op(input logic [3:0] c, input logic [31:0] d, s, input logic [4:0] b, input logic l);
      int i;
      @(negedge mclk_i);
      {op_code_i, data_register_i, src_i, bit_num_i, bit_long_i, op_start_i} = {c, d, s, b, l, 1'h1};
      @(negedge mclk_i);
      op_start_i = 1'h0;
      for (i = 0; i < 4 && done_o !== 1'h1; i++) @(negedge mclk_i);
      ck("done", 32'h1, {31'h0, done_o});
   endtask
   task automatic opx(input logic [3:0] c, input logic [31:0] d, s, input logic [4:0] b, input logic l,
         input logic [31:0] er, input logic [4:0] ec, m, input logic et);
      op(c, d, s, b, l);
      ck("result", er, result_o);
      ck("ccr", {27'h0, ec & m}, {27'h0, ccr_o & m});
      ck("trap", {31'h0, et}, {31'h0, trap_o});
   endtask
   task automatic t_sign_bound();
      opx(COU_OP_SIGN_W, 32'hFFFF_0080, 0, 0, 0, 32'hFFFF_FF80, 5'h08, 5'h1F, 0);
      opx(COU_OP_SIGN_L, 32'hFFFF_1234, 0, 0, 0, 32'h0000_1234, 5'h00, 5'h1F, 0);
      opx(COU_OP_BOUND, 32'h0000_FFFF, 32'h0000_0010, 0, 0, 32'h0000_FFFF, 5'h08, 5'h1F, 1);
      opx(COU_OP_BOUND, 32'h0000_0005, 32'h0000_0004, 0, 0, 32'h0000_0005, 5'h00, 5'h1F, 1);
      opx(COU_OP_BOUND, 32'h0000_0004, 32'h0000_0004, 0, 0, 32'h0000_0004, 5'h00, 5'h1F, 0);
      opx(COU_OP_BOUND, 32'h0000_0000, 32'h0000_0004, 0, 0, 32'h0000_0000, 5'h00, 5'h1F, 0);
      $display("test sign_bound done");
   endtask
   task automatic t_div();
      opx(COU_OP_SDIV, 32'h0000_0064, 32'h0000_0007, 0, 0, 32'h0002_000E, 5'h00, 5'h1F, 0);
      opx(COU_OP_SDIV, 32'hFFFF_FF9C, 32'h0000_0007, 0, 0, 32'hFFFE_FFF2, 5'h08, 5'h1F, 0);
      opx(COU_OP_SDIV, 32'h7FFF_FFFF, 32'h0000_0001, 0, 0, 32'h7FFF_FFFF, 5'h02, 5'h03, 0);
      opx(COU_OP_SDIV, 32'h0000_0064, 32'h0000_0000, 0, 0, 32'h0000_0064, 5'h0A, 5'h1F, 1);
      $display("test div done");
   endtask
   task automatic t_bit_dec();
      opx(COU_OP_SIGN_L, 32'h0000_0001, 0, 0, 0, 32'h0000_0001, 5'h00, 5'h1F, 0);
      opx(COU_OP_BIT_CLR, 32'h0000_0010, 0, 5'h04, 1, 32'h0000_0000, 5'h00, 5'h1F, 0);
      opx(COU_OP_BIT_SET, 32'h0000_0000, 0, 5'h04, 1, 32'h0000_0010, 5'h04, 5'h1F, 0);
      opx(COU_OP_BIT_INV, 32'h0000_0008, 0, 5'h0B, 0, 32'h0000_0000, 5'h00, 5'h1F, 0);
      opx(COU_OP_BIT_INV, 32'h0000_0000, 0, 5'h1F, 1, 32'h8000_0000, 5'h04, 5'h1F, 0);
      opx(4'hF, 32'h1357_9BDF, 0, 0, 0, 32'h1357_9BDF, 5'h04, 5'h1F, 0);
      opx(COU_OP_DEC_ADD, 32'hABCD_EF45, 32'h0000_0038, 0, 0, 32'hABCD_EF83, 5'h00, 5'h1F, 0);
      opx(COU_OP_DEC_ADD, 32'h0000_0099, 32'h0000_0001, 0, 0, 32'h0000_0000, 5'h11, 5'h1F, 0);
      opx(COU_OP_DEC_ADD, 32'h0000_0010, 32'h0000_0020, 0, 0, 32'h0000_0031, 5'h00, 5'h1F, 0);
      $display("test bit_dec done");
   endtask
   task automatic t_link();
      op(COU_OP_LINK, 32'h0, 32'h0000_FFF8, 0, 0);
      ck("push", 32'h1, {31'h0, push_o});
      ck("push_addr", 32'h0000_1FFC, push_addr_o);
      ck("push_data", 32'h0000_1000, push_data_o);
      ck("areg", 32'h0000_1FFC, areg_o);
      ck("sp", 32'h0000_1FF4, sp_o);
      ck("ccr", 32'h0, {27'h0, ccr_o});
      $display("test link done");
   endtask
   // two long registers, prompt then slow memory; start held into busy must be ignored
   task automatic t_mm();
      int i, k;
      // a start with a zero count is ignored and reads nothing
      @(negedge mclk_i);
      {mm_count_i, mm_start_i} = {4'h0, 1'h1};
      @(negedge mclk_i);
      mm_start_i = 1'h0;
      ck("busy", 32'h0, {31'h0, mm_busy_o});
      ck("reads", 32'h0, 32'(rd_q.size()));
      for (k = 0; k < 2; k++) begin
         rd_q.delete();
         ld_q.delete();
         @(negedge mclk_i);
         {slow, mm_addr_i, mm_first_i, mm_count_i, mm_start_i} = {k[0], 32'h0000_0100, 4'h3, 4'h2, 1'h1};
         repeat (2) @(negedge mclk_i);
         mm_start_i = 1'h0;
         for (i = 0; i < 100 && mm_busy_o !== 1'h0; i++) @(negedge mclk_i);
         ck("reads", 32'h5, 32'(rd_q.size()));
         for (i = 0; i < 5; i++) ck("raddr", 32'h100 + 32'(2 * i), rd_q[i]);
         ck("loads", 32'h2, 32'(ld_q.size()));
         for (i = 0; i < 2; i++) begin
            ck("ldidx", 32'(3 + i), {28'h0, ld_q[i][35:32]});
            ck("lddata", {mw(32'h100 + 32'(4 * i)), mw(32'h102 + 32'(4 * i))}, ld_q[i][31:0]);
         end
      end
      $display("test mm done");
   endtask
   task automatic final_report();
      $display("checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(negedge mclk_i);
      rst_i = 1'h0;
      t_sign_bound();
      t_div();
      t_bit_dec();
      t_link();
      t_mm();
      final_report();
   end
endmodule
`default_nettype wire
